/* File: core/psm_core.v */
// Parameter-set manager: working, stored application and factory sets.
// Overview of operation
// - Power-up loads working set from stored set.
// - Working set readable any time, writable only while idle.
// - Save write copies working set to storage.
// - Restore write copies factory defaults to working.
// - Restore only while power stage disabled.
// - Factory defaults are fixed, never written.
// - Parameters equal defaults after restore.
// - Missing subindex is treated as zero.
// - Attention shown until drive is parameterised.
// - Restore needs the load key, else error.
// - Restore with stage enabled aborts, state error.
// - Save is acknowledged immediately by default.
`timescale 1ns/100ps
`include "psm_defs.vh"
////////////////////////////////////////////////////////////////////
// Interface notes.
// A request is taken on a clock edge with CE high, REQ high and the
// sequencer idle; ACK follows one cycle later and ABORT stands with it
// until the next request is answered.
// Requests that arrive while a copy runs are answered at once with the
// busy abort code, so the master never waits on a silent channel.
// The working set lives in a local array; the factory table is a
// separate read-only lookup, so no path exists that could write it.
// Storage is read with a combinational answer: the word for NV_ADDR is
// expected on NV_RDATA in the cycle after NV_ADDR was set.
// Limitation: direct parameter writes are only honoured while idle, so a
// write issued during a boot, save or restore copy is lost.
// Trade-off: the delayed save answer keeps the master in step with the
// storage, at the price of a long wait for that single answer.
// Nothing is taken before the boot copy ends, since reset starts the sequencer in the boot state.
////////////////////////////////////////////////////////////////////
module psm_core (
	// Clock, reset, enable.
	input  wire                CLK,
	input  wire                RST,
	input  wire                CE,
	// Object access request from the fieldbus side.
	input  wire                REQ,
	input  wire                WRITE,
	input  wire [15:0]         INDEX,
	input  wire                SUB_GIVEN,
	input  wire [7:0]          SUBINDEX,
	input  wire [31:0]         WDATA,
	// Direct working-set parameter access.
	input  wire                PAR_WE,
	input  wire [`PSM_AW-1:0]  PAR_ADDR,
	input  wire [`PSM_DW-1:0]  PAR_WDATA,
	output reg  [`PSM_DW-1:0]  PAR_RDATA,
	// Non-volatile memory port, one word every two cycles at most, ready handshake.
	output reg                 NV_WE,
	output reg  [`PSM_AW-1:0]  NV_ADDR,
	output reg  [`PSM_DW-1:0]  NV_WDATA,
	input  wire [`PSM_DW-1:0]  NV_RDATA,
	input  wire                NV_READY,
	// Drive status and configuration.
	input  wire                STAGE_ON,
	input  wire                RESP_AFTER_SAVE,
	// Answer and status.
	output reg                 ACK,
	output reg  [31:0]         ABORT,
	output reg  [31:0]         RDATA,
	output reg                 BUSY,
	output reg                 READY,
	output reg                 ATTENTION
);
	// Working set, sequencer state and copy pointer.
	reg  [`PSM_DW-1:0] work [0:`PSM_DEPTH-1];
	reg  [2:0]         state;
	reg  [`PSM_AW-1:0] ptr;
	reg                hold_ack;
	// Factory table output and decoded object writes.
	wire [`PSM_DW-1:0] def_data;
	wire [7:0]         sub;
	wire               wr_save;
	wire               wr_rest;
	wire               wr_comm;

	////////////////////////////////////////////////////////////////////
	psm_defaults u_def (
		.addr (ptr),
		.data (def_data)
	);

	assign sub     = SUB_GIVEN ? SUBINDEX : `PSM_SUB_ZERO;
	// Decoded writes to the save, restore and commissioning entries.
	assign wr_save = REQ & WRITE & (INDEX == `PSM_IDX_SAVE) & (sub == `PSM_SUB_ONE);
	assign wr_rest = REQ & WRITE & (INDEX == `PSM_IDX_RESTORE) & (sub == `PSM_SUB_ONE);
	assign wr_comm = REQ & WRITE & (INDEX == `PSM_IDX_DRIVE_DATA)
		& (sub == `PSM_SUB_COMMISSION);

	////////////////////////////////////////////////////////////////////
	// Sequencer; NV is read with one-cycle latency once NV_READY is high.
	always @(posedge CLK) begin
		// Reset starts in the boot state, so nothing is taken before the boot copy.
		if (RST) begin
			state     <= `PSM_ST_BOOT;
			ptr       <= `PSM_ADDR_ZERO;
			hold_ack  <= 1'b0;
			ACK       <= 1'b0;
			ABORT     <= `PSM_ABORT_NONE;
			RDATA     <= `PSM_WORD_ZERO;
			BUSY      <= 1'b1;
			READY     <= 1'b0;
			ATTENTION <= 1'b1;
			NV_WE     <= 1'b0;
			NV_ADDR   <= `PSM_ADDR_ZERO;
			NV_WDATA  <= `PSM_WORD_ZERO;
			PAR_RDATA <= `PSM_WORD_ZERO;
		end else if (CE) begin
			// Pulsed outputs drop unless a branch below raises them.
			ACK       <= 1'b0;
			NV_WE     <= 1'b0;
			// Read port follows PAR_ADDR with one cycle of latency.
			PAR_RDATA <= work[PAR_ADDR];
			if (wr_comm)
				ATTENTION <= 1'b0;
			case (state)
				// load working set from storage at power-up
				`PSM_ST_BOOT: begin
					// Present the address; step on only when storage is ready.
					NV_ADDR <= ptr;
					if (NV_READY)
						state <= `PSM_ST_BOOTWAIT;
				end
				`PSM_ST_BOOTWAIT: begin
					// The stored word stands on NV_RDATA now; take it and step on.
					work[ptr] <= NV_RDATA;
					ptr       <= ptr + `PSM_ADDR_STEP;
					state     <= `PSM_ST_BOOT;
					if (ptr == `PSM_LAST_ADDR) begin
						state <= `PSM_ST_IDLE;
						BUSY  <= 1'b0;
						READY <= 1'b1;
					end
				end
				`PSM_ST_IDLE: begin
					// working set written any time when idle
					if (PAR_WE)
						work[PAR_ADDR] <= PAR_WDATA;
					if (REQ) begin
						// Every taken request is answered; ABORT is clean unless refused.
						ABORT <= `PSM_ABORT_NONE;
						RDATA <= `PSM_WORD_ZERO;
						ACK   <= 1'b1;
						ptr   <= `PSM_ADDR_ZERO;
						// A read of the save or restore entry reports support.
						if (!WRITE && (sub == `PSM_SUB_ONE) &&
							(INDEX == `PSM_IDX_SAVE || INDEX == `PSM_IDX_RESTORE))
							RDATA <= `PSM_RD_SUPPORTED;
						if (wr_save) begin
							// start copy to storage
							// The save value is not checked; any write here saves.
							state <= `PSM_ST_SAVE;
							BUSY  <= 1'b1;
							ACK      <= ~RESP_AFTER_SAVE;
							hold_ack <= RESP_AFTER_SAVE;
						end else if (wr_rest) begin
							if (STAGE_ON)
								ABORT <= `PSM_ABORT_STATE;
							else if (WDATA != `PSM_KEY_LOAD)
								ABORT <= `PSM_ABORT_ACCESS;
							else begin
								state <= `PSM_ST_RESTORE;
								BUSY  <= 1'b1;
							end
						end
					end
				end
				`PSM_ST_SAVE: begin
					// One word per ready cycle in SAVE, then one SAVEWAIT cycle; address and data stand with NV_WE.
					if (NV_READY) begin
						NV_WE    <= 1'b1;
						NV_ADDR  <= ptr;
						NV_WDATA <= work[ptr];
						state    <= `PSM_ST_SAVEWAIT;
					end
				end
				`PSM_ST_SAVEWAIT: begin
					// Storage took the word; move on, or finish and release.
					ptr   <= ptr + `PSM_ADDR_STEP;
					state <= `PSM_ST_SAVE;
					if (ptr == `PSM_LAST_ADDR) begin
						state    <= `PSM_ST_IDLE;
						BUSY     <= 1'b0;
						ACK      <= hold_ack;
						hold_ack <= 1'b0;
					end
				end
				// copy defaults; fixed table gives defaults
				`PSM_ST_RESTORE: begin
					// The table answers at once, so one word lands each cycle.
					work[ptr] <= def_data;
					ptr       <= ptr + `PSM_ADDR_STEP;
					if (ptr == `PSM_LAST_ADDR) begin
						state <= `PSM_ST_IDLE;
						BUSY  <= 1'b0;
					end
				end
				// Unused codes fall back to idle rather than hang.
				default: state <= `PSM_ST_IDLE;
			endcase
			// requests while busy are refused
			// Answering at once keeps the master from timing out on a copy.
			if (REQ && state != `PSM_ST_IDLE) begin
				ACK   <= 1'b1;
				ABORT <= `PSM_ABORT_BUSY;
			end
		end
	end
endmodule

/* File: core/psm_defs.vh */
// Constants for the parameter-set manager.
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
`define PSM_AW              4
`define PSM_DW              32
`define PSM_DEPTH           16
`define PSM_LAST_ADDR       4'hF
`define PSM_IDX_SAVE        16'h1010
`define PSM_IDX_RESTORE     16'h1011
`define PSM_IDX_DRIVE_DATA  16'h6510
`define PSM_SUB_ONE         8'h01
`define PSM_SUB_ZERO        8'h00
`define PSM_SUB_COMMISSION  8'hC0
`define PSM_ADDR_ZERO       4'h0
`define PSM_ADDR_STEP       4'h1
`define PSM_WORD_ZERO       32'h00000000
`define PSM_RD_SUPPORTED    32'h00000001
`define PSM_DEF_W1          32'h00000001
`define PSM_DEF_W2          32'h00000064
`define PSM_DEF_W3          32'h000003E8
`define PSM_KEY_LOAD        32'h64616F6C
`define PSM_KEY_SAVE        32'h65766173
`define PSM_ABORT_NONE      32'h00000000
`define PSM_ABORT_STATE     32'h08000022
`define PSM_ABORT_ACCESS    32'h08000020
`define PSM_ABORT_BUSY      32'h08000021
`define PSM_ST_BOOT         3'h0
`define PSM_ST_IDLE         3'h1
`define PSM_ST_SAVE         3'h2
`define PSM_ST_RESTORE      3'h3
`define PSM_ST_BOOTWAIT     3'h4
`define PSM_ST_SAVEWAIT     3'h5
`endif

/* File: core/psm_defaults.v */
// Fixed factory default parameter table, read only.
`timescale 1ns/100ps
`include "psm_defs.vh"
module psm_defaults (
	// Table lookup.
	input  wire [`PSM_AW-1:0] addr,
	output reg  [`PSM_DW-1:0] data
);
	// no write path
	// Constant content; nothing can write it, so defaults never drift.
	always @* begin
		data = `PSM_WORD_ZERO;
		case (addr)
			4'h1: data = `PSM_DEF_W1;
			4'h2: data = `PSM_DEF_W2;
			4'h3: data = `PSM_DEF_W3;
			default: data = `PSM_WORD_ZERO;
		endcase
	end
endmodule

/* File: tb/psm_checker.sv */
// Port assertions for the parameter-set manager.
`timescale 1ns/100ps
module psm_checker (
	input wire        CLK, RST, CE, REQ, WRITE, SUB_GIVEN, STAGE_ON, RESP_AFTER_SAVE,
	input wire        ACK, BUSY, READY, ATTENTION, NV_WE,
	input wire [15:0] INDEX,
	input wire [7:0]  SUBINDEX,
	input wire [31:0] WDATA, ABORT
);
	// Taken request, and a restore with the stage off.
	wire go = REQ && CE && !BUSY;
	wire rs = go && WRITE && INDEX == 16'h1011 && SUB_GIVEN && SUBINDEX == 8'h01;
	wire rk = rs && !STAGE_ON;
	wire ky = WDATA == 32'h64616F6C;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_save;
		go && WRITE && INDEX == 16'h1010 ##1 BUSY;
	endsequence
	chk_quick_ack: assert property (go && !RESP_AFTER_SAVE |=> ACK)
		else $error("ack");
	chk_stage_lock: assert property (rs && STAGE_ON |=> ABORT == 32'h08000022 && !BUSY)
		else $error("stage");
	chk_load_key: assert property (rk && !ky |=> ABORT == 32'h08000020)
		else $error("key");
	chk_restore_run: assert property (rk && ky |=> (ABORT == 32'h0 && BUSY) [*8])
		else $error("restore");
	chk_restore_nvq: assert property (rk && ky |=> !NV_WE [*8])
		else $error("nv");
	chk_busy_refuse: assert property (REQ && CE && BUSY && READY
		|=> ACK && ABORT == 32'h08000021)
		else $error("busy");
	chk_save_copy: assert property (s_save |-> ##[1:200] NV_WE)
		else $error("save");
	chk_attn_clear: assert property ($fell(ATTENTION) |-> $past(INDEX) == 16'h6510)
		else $error("attn");
endmodule
bind psm_core psm_checker i_chk (.CLK, .RST, .CE, .REQ, .WRITE, .SUB_GIVEN, .STAGE_ON,
	.RESP_AFTER_SAVE, .ACK, .BUSY, .READY, .ATTENTION, .NV_WE, .INDEX, .SUBINDEX, .WDATA, .ABORT);

/* File: tb/psm_nvmem.sv */
// Storage model behind the non-volatile port.
`timescale 1ns/100ps
module psm_nvmem (
	input wire        CLK, WE, SLOW,
	input wire [3:0]  ADDR,
	input wire [31:0] WDATA,
	output wire [31:0] RDATA,
	output reg        RDY
);
	reg [31:0] mem [0:15];
	integer i;
	// Known stored pattern, so the boot copy can be seen.
	initial begin
		for (i = 0; i < 16; i = i + 1) mem[i] = 32'hA5000000 + i;
		RDY = 1'b1;
	end
	// The word at ADDR stands in the cycle after ADDR changes, when it is sampled.
	assign RDATA = mem[ADDR];
	// Slow mode halves the ready rate to stress the handshake.
	always @(posedge CLK) begin
		RDY <= SLOW ? ~RDY : 1'b1;
		if (WE) mem[ADDR] <= WDATA;
	end
endmodule

/* File: tb/tb_parameter_set_manager.sv */
// Self-checking bench for the parameter-set manager.
`timescale 1ns/100ps
module tb_parameter_set_manager;
	reg         CLK = 0, RST = 1, REQ = 0, WRITE = 0, PAR_WE = 0, STAGE_ON = 0, SLOW = 1;
	reg         CE = 1, SUB_GIVEN = 1, RESP_AFTER_SAVE = 0;
	reg  [15:0] INDEX = 0;
	reg  [7:0]  SUBINDEX = 1;
	reg  [3:0]  PAR_ADDR = 0;
	reg  [31:0] WDATA = 0, PAR_WDATA = 0, model [0:15];
	wire [31:0] PAR_RDATA, NV_WDATA, NV_RDATA, ABORT, RDATA;
	wire [3:0]  NV_ADDR;
	wire        NV_WE, NV_READY, ACK, BUSY, READY, ATTENTION;
	integer     failures = 0, comparisons = 0, seed = 32'h3cc321e2, i, n;
	psm_core i_psm_core (.CLK, .RST, .CE, .REQ, .WRITE, .INDEX, .SUB_GIVEN, .SUBINDEX,
		.WDATA, .PAR_WE, .PAR_ADDR, .PAR_WDATA, .PAR_RDATA, .NV_WE, .NV_ADDR, .NV_WDATA, .NV_RDATA,
		.NV_READY, .STAGE_ON, .RESP_AFTER_SAVE, .ACK, .ABORT, .RDATA, .BUSY, .READY, .ATTENTION);
	psm_nvmem i_psm_nvmem (.CLK, .WE(NV_WE), .SLOW, .ADDR(NV_ADDR), .WDATA(NV_WDATA),
		.RDATA(NV_RDATA), .RDY(NV_READY));
	// Clock.
	initial forever #12.5 CLK = ~CLK;
	task chk(input [31:0] s, input [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	// One request; the answer is looked at in the cycle it stands.
	task rq(input w, input [15:0] x, input [7:0] s, input [31:0] d, input [31:0] ab);
		begin
			@(posedge CLK);
			{REQ, WRITE, INDEX, SUBINDEX, WDATA} <= {1'b1, w, x, s, d};
			@(posedge CLK);
			REQ <= 0;
			#1 chk(ACK, 1);
			chk(ABORT, ab);
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge CLK) PAR_ADDR <= a;
			@(posedge CLK);
			@(posedge CLK) #1 chk(PAR_RDATA, model[a]);
		end
	endtask
	// Wait for the copy to end; a limit that runs out is a mismatch.
	task wb;
		begin
			for (n = 0; n < 300 && BUSY !== 1'b0; n = n + 1) @(posedge CLK) #1;
			chk(BUSY, 0);
		end
	endtask
	task complete_run;
		begin
			$display("comparisons %0d failures %0d", comparisons, failures);
			if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Main sequence.
	initial begin
		for (i = 0; i < 16; i = i + 1) model[i] = 32'hA5000000 + i;
		repeat (6) @(posedge CLK);
		RST <= 0;
		wb;
		chk({READY, ATTENTION}, 2'h3);
		for (i = 0; i < 16; i = i + 1) rd(i);
		$display("boot done");
		SLOW <= 0;
		for (i = 0; i < 16; i = i + 1) begin
			n = $random(seed);
			@(posedge CLK) {PAR_WE, PAR_ADDR, PAR_WDATA} <= {1'b1, i[3:0], n};
			model[i] = n;
		end
		@(posedge CLK) PAR_WE <= 0;
		for (i = 0; i < 16; i = i + 1) rd(i);
		rq(1, 16'h1010, 8'h01, 32'h65766173, 0);
		rq(1, 16'h1011, 8'h01, 32'h64616F6C, 32'h08000021);
		wb;
		for (i = 0; i < 16; i = i + 1) chk(i_psm_nvmem.mem[i], model[i]);
		$display("save done");
		@(posedge CLK) STAGE_ON <= 1;
		rq(1, 16'h1011, 8'h01, 32'h64616F6C, 32'h08000022);
		@(posedge CLK) STAGE_ON <= 0;
		rd(5);
		@(posedge CLK) SUB_GIVEN <= 0;
		rq(1, 16'h1011, 8'h01, 32'h64616F6C, 0);
		chk(BUSY, 0);
		@(posedge CLK) SUB_GIVEN <= 1;
		rd(5);
		$display("subindex done");
		rq(1, 16'h1011, 8'h01, 32'h65766173, 32'h08000020);
		rq(1, 16'h1011, 8'h01, 32'h64616F6C, 0);
		wb;
		for (i = 0; i < 16; i = i + 1)
			model[i] = (i == 1) ? 1 : (i == 2) ? 32'h64 : (i == 3) ? 32'h3E8 : 0;
		for (i = 0; i < 16; i = i + 1) rd(i);
		// after a restore one parameter is written and read back, then the restore entry reads as supported.
		n = $random(seed);
		@(posedge CLK) {PAR_WE, PAR_ADDR, PAR_WDATA} <= {1'b1, 4'h7, n};
		model[7] = n;
		@(posedge CLK) PAR_WE <= 0;
		rd(7);
		rq(0, 16'h1011, 8'h01, 0, 0);
		chk(RDATA, 1);
		$display("restore done");
		// delayed answer comes at the end of the save.
		@(posedge CLK) RESP_AFTER_SAVE <= 1;
		@(posedge CLK) begin
			{REQ, WRITE, INDEX, SUBINDEX} <= {1'b1, 1'b1, 16'h1010, 8'h01};
			WDATA <= 32'h65766173;
		end
		@(posedge CLK) REQ <= 0;
		#1 chk(ACK, 0);
		chk(BUSY, 1);
		for (n = 0; n < 300 && ACK !== 1'b1; n = n + 1) @(posedge CLK) #1;
		chk(ACK, 1);
		chk(BUSY, 0);
		for (i = 0; i < 16; i = i + 1) chk(i_psm_nvmem.mem[i], model[i]);
		@(posedge CLK) RESP_AFTER_SAVE <= 0;
		$display("delayed save done");
		@(posedge CLK) begin
			{CE, REQ, WRITE} <= 3'h3;
			{INDEX, SUBINDEX} <= {16'h6510, 8'hC0};
		end
		@(posedge CLK) REQ <= 0;
		#1 chk(ACK, 0);
		chk(ATTENTION, 1);
		@(posedge CLK) CE <= 1;
		$display("freeze done");
		rq(1, 16'h6510, 8'hC0, 0, 0);
		@(posedge CLK) #1 chk(ATTENTION, 0);
		$display("commission done");
		complete_run;
	end
	// Watchdog.
	initial begin
		#100000;
		failures = failures + 1;
		complete_run;
	end
endmodule
